// ---- common/dac_load_pkg.sv ----
// What this block does
// - select low opens a frame; data input sampled on rising serial clock
// - serial output changes only at select fall or on falling serial clock while selected
// - frame shorter than 24 rising edges is dropped at select release
// - beyond 24 edges bits keep flowing through the shift register
// - select release decodes the last 24 bits, load pin considered
// - 24-bit shift register, msb first, old bits leave on serial output
// - serial output undriven whenever select is high
// - select fall shows top bit; changes from first falling after a rise
// - frame is an 8-bit command then 16 data bits
// - register read needs two frames; second returns command copy plus data
// - read commands copy preload, output or setup into shift register
// - no bit counting for decode; decode only on select release
// - power-up output is zero or midscale per the selection pin with SYNC_STAGES of 2; always midscale with more stages
// - transfer mode 0 keeps written data in preload until a load
// - transfer mode 1 writes preload and output together at release
// - only the output register drives the converted level
// - load pin low copies preload to output, level sensitive
// - load pin held low updates output at each select release
// - soft load command copies preload to output
// - mode write obeys mode bit; update and write-all always write both
// - setup bits power down amplifier, output floating or pulled down
// - clear pin low forces output to the power-up level, level sensitive
package dac_load_pkg;
    localparam int FRAME_BITS = 24;
    localparam int DATA_BITS  = 16;
    localparam int CMD_BITS   = 8;

    // command byte: opcode in the top five bits, channel in the low three
    typedef struct packed {
        logic [4:0] opcode;
        logic [2:0] chan;
    } spi_cmd_t;

    typedef struct packed {
        logic mode;     // transfer_mode_bit
        logic sel_10k;
        logic sel_hiz;
    } setup_t;

    localparam logic [4:0] OP_WRITE_MODE   = 5'h01;
    localparam logic [4:0] OP_UPDATE_WRITE = 5'h02; // update_write_cmd
    localparam logic [4:0] OP_WRITE_ALL    = 5'h03; // write_all_cmd
    localparam logic [4:0] OP_SOFT_LOAD    = 5'h04; // soft_load_cmd
    localparam logic [4:0] OP_SOFT_CLEAR   = 5'h05;
    localparam logic [4:0] OP_POWER_DOWN   = 5'h06;
    localparam logic [4:0] OP_SET_MODE     = 5'h07;
    localparam logic [4:0] OP_READ_PRELOAD = 5'h08; // read_preload_cmd
    localparam logic [4:0] OP_READ_OUTPUT  = 5'h09; // read_output_cmd
    localparam logic [4:0] OP_READ_SETUP   = 5'h0a; // read_setup_cmd
    localparam logic [2:0] CHAN_ZERO       = 3'h0;

    localparam logic [15:0] CODE_ZERO     = 16'h0000;
    localparam logic [15:0] CODE_MIDSCALE = 16'h8000;
    localparam setup_t      SETUP_RESET   = '{mode: 1'b0, sel_10k: 1'b0, sel_hiz: 1'b0};
    localparam logic [4:0]  EDGE_CNT_MAX  = 5'h18;

    // wishbone register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_PRELOAD = 8'h04;
    localparam logic [7:0] OFS_OUTPUT  = 8'h08;
    localparam logic [7:0] OFS_SETUP   = 8'h0c;
    localparam logic [7:0] OFS_FRAMES  = 8'h10;
    localparam logic       CTRL_RESET  = 1'b1;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// ---- design/dac_serial_load_control.sv ----
`timescale 1ns/1ps
module dac_serial_load_control
    import dac_load_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // serial link pins
    input  wire logic        select_n_i,
    input  wire logic        sclk_i,
    input  wire logic        sdi_i,
    output logic             sdo_o,
    output logic             sdo_oe_o,
    // level pins
    input  wire logic        load_out_pin_n_i,
    input  wire logic        clear_out_pin_n_i,
    input  wire logic        powerup_level_sel_i,
    // converter side
    output logic [15:0]      dac_code_o,
    output logic             amp_power_down_o,
    output logic             out_pulldown_o,
    output logic             out_hiz_o,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o
);
    // elaboration check: a single stage cannot settle a metastable pin
    if (SYNC_STAGES < 2) begin : bad_sync_stages
        $error("SYNC_STAGES must be at least 2");
    end

    localparam int NPIN = 6;

    // all pins are asynchronous to clk_i; one extra stage for edge finding
    logic [NPIN-1:0] sync_reg [SYNC_STAGES];
    logic [NPIN-1:0] pins_d;
    logic [NPIN-1:0] pins_q;
    logic            sclk_prev_reg;
    logic            sel_prev_reg;

    assign pins_d = {powerup_level_sel_i, clear_out_pin_n_i, load_out_pin_n_i,
                     sdi_i, sclk_i, select_n_i};
    assign pins_q = sync_reg[SYNC_STAGES-1];

    // synchroniser chain, first stage feeds only the next stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                sync_reg[i] <= 6'h3f;
            end
        end else begin
            sync_reg[0] <= pins_d;
            for (int i = 1; i < SYNC_STAGES; i++) begin
                sync_reg[i] <= sync_reg[i-1];
            end
        end
    end

    logic select_n_s;
    logic sclk_s;
    logic sdi_s;
    logic load_n_s;
    logic clear_n_s;
    logic level_sel_s;

    assign select_n_s  = pins_q[0];
    assign sclk_s      = pins_q[1];
    assign sdi_s       = pins_q[2];
    assign load_n_s    = pins_q[3];
    assign clear_n_s   = pins_q[4];
    assign level_sel_s = pins_q[5];

    // edge history on synchronised copies
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_prev_reg <= 1'b1;
            sel_prev_reg  <= 1'b1;
        end else begin
            sclk_prev_reg <= sclk_s;
            sel_prev_reg  <= select_n_s;
        end
    end

    logic link_en_reg;
    logic sel_fall;
    logic sel_rise;
    logic selected;
    logic sclk_rise;
    logic sclk_fall;
    logic in_frame_reg;

    assign selected  = ~select_n_s;
    assign sel_fall  = sel_prev_reg & ~select_n_s & link_en_reg;
    assign sel_rise  = ~sel_prev_reg & select_n_s & in_frame_reg;
    assign sclk_rise = ~sclk_prev_reg & sclk_s;
    assign sclk_fall = sclk_prev_reg & ~sclk_s;

    // frame tracking; a disabled link ignores new frames only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_frame_reg <= 1'b0;
        end else if (sel_fall) begin
            in_frame_reg <= 1'b1;
        end else if (select_n_s) begin
            in_frame_reg <= 1'b0;
        end
    end

    logic [4:0] edge_cnt_reg;
    logic       frame_full;

    // counts only to tell a short frame; decode never depends on position
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_cnt_reg <= 5'h00;
        end else if (sel_fall) begin
            edge_cnt_reg <= 5'h00;
        end else if (in_frame_reg && selected && sclk_rise && edge_cnt_reg != EDGE_CNT_MAX) begin
            edge_cnt_reg <= edge_cnt_reg + 5'h01;
        end
    end
    assign frame_full = (edge_cnt_reg == EDGE_CNT_MAX);

    logic [FRAME_BITS-1:0] shift_reg;
    logic [FRAME_BITS-1:0] read_load;
    logic                  read_hit;
    logic                  shift_phase_reg;
    logic                  sdo_reg;
    logic                  sdo_oe_reg;

    // sampled on rising clock, msb first; keeps shifting past 24 bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_reg <= 24'h00_0000;
        end else if (in_frame_reg && selected && sclk_rise) begin
            shift_reg <= {shift_reg[FRAME_BITS-2:0], sdi_s};
        end else if (read_hit) begin
            shift_reg <= read_load;
        end
    end

    // serial output: no change before the first rising edge of the frame
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sdo_reg         <= 1'b0;
            sdo_oe_reg      <= 1'b0;
            shift_phase_reg <= 1'b0;
        end else if (sel_fall) begin
            sdo_reg         <= shift_reg[FRAME_BITS-1];
            sdo_oe_reg      <= 1'b1;
            shift_phase_reg <= 1'b0;
        end else if (!in_frame_reg || select_n_s) begin
            sdo_oe_reg      <= 1'b0;
            shift_phase_reg <= 1'b0;
        end else begin
            if (sclk_rise) begin
                shift_phase_reg <= 1'b1;
            end
            if (sclk_fall && shift_phase_reg) begin
                sdo_reg <= shift_reg[FRAME_BITS-1];
            end
        end
    end

    // decode of the last frame
    spi_cmd_t       cmd;
    logic [15:0]    data_word;
    logic           decode;
    logic           chan_ok;

    assign cmd       = spi_cmd_t'(shift_reg[FRAME_BITS-1 -: CMD_BITS]);
    assign data_word = shift_reg[DATA_BITS-1:0];
    assign decode    = sel_rise & frame_full;
    assign chan_ok   = (cmd.chan == CHAN_ZERO);

    logic [15:0] preload_reg;
    logic [15:0] output_reg;
    setup_t      setup_reg;
    logic [15:0] preload_next;
    logic [15:0] output_next;
    setup_t      setup_next;
    logic [15:0] strap_code;
    logic [1:0]  init_cnt_reg;
    logic        init_pending;

    assign strap_code   = level_sel_s ? CODE_MIDSCALE : CODE_ZERO;
    assign init_pending = (init_cnt_reg != 2'h3);

    // strap is caught at the third edge after release; only with SYNC_STAGES of 2 does the synchroniser hold the pin by then
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            init_cnt_reg <= 2'h0;
        end else if (init_pending) begin
            init_cnt_reg <= init_cnt_reg + 2'h1;
        end
    end

    // read commands pick the register copied back into the shift register
    always_comb begin
        read_hit  = 1'b0;
        read_load = shift_reg;
        if (decode && chan_ok) begin
            unique case (cmd.opcode)
                OP_READ_PRELOAD: begin
                    read_hit  = 1'b1;
                    read_load = {shift_reg[FRAME_BITS-1 -: CMD_BITS], preload_reg};
                end
                OP_READ_OUTPUT: begin
                    read_hit  = 1'b1;
                    read_load = {shift_reg[FRAME_BITS-1 -: CMD_BITS], output_reg};
                end
                OP_READ_SETUP: begin
                    read_hit  = 1'b1;
                    read_load = {shift_reg[FRAME_BITS-1 -: CMD_BITS], 13'h0000, setup_reg};
                end
                default: begin
                    read_hit  = 1'b0;
                end
            endcase
        end
    end

    logic soft_clear;

    // command effects, then the level pins; clear pin has the last word
    always_comb begin
        preload_next = preload_reg;
        output_next  = output_reg;
        setup_next   = setup_reg;
        soft_clear   = 1'b0;
        if (decode && chan_ok) begin
            unique case (cmd.opcode)
                OP_WRITE_MODE: begin
                    preload_next = data_word;
                    if (setup_reg.mode) begin
                        output_next = data_word;
                    end
                end
                OP_UPDATE_WRITE, OP_WRITE_ALL: begin
                    preload_next = data_word;
                    output_next  = data_word;
                end
                OP_SOFT_LOAD: begin
                    output_next = preload_reg;
                end
                OP_SOFT_CLEAR: begin
                    soft_clear = 1'b1;
                end
                OP_POWER_DOWN: begin
                    setup_next.sel_10k = data_word[1];
                    setup_next.sel_hiz = data_word[0];
                end
                OP_SET_MODE: begin
                    setup_next.mode = data_word[0];
                end
                default: begin
                    // reads handled above; unknown codes change nothing
                    preload_next = preload_reg;
                end
            endcase
        end
        if (!load_n_s) begin
            output_next = preload_next;
        end
        if (!clear_n_s || soft_clear || init_pending) begin
            output_next = strap_code;
        end
    end

    // data and setup registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            preload_reg <= CODE_ZERO;
            output_reg  <= CODE_ZERO;
            setup_reg   <= SETUP_RESET;
        end else begin
            preload_reg <= preload_next;
            output_reg  <= output_next;
            setup_reg   <= setup_next;
        end
    end

    // converter drive; only the output register reaches the level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dac_code_o       <= CODE_ZERO;
            amp_power_down_o <= 1'b0;
            out_pulldown_o   <= 1'b0;
            out_hiz_o        <= 1'b0;
        end else begin
            dac_code_o       <= output_next;
            amp_power_down_o <= setup_next.sel_10k | setup_next.sel_hiz;
            out_pulldown_o   <= setup_next.sel_10k & ~setup_next.sel_hiz;
            out_hiz_o        <= setup_next.sel_hiz;
        end
    end

    assign sdo_o    = sdo_reg;
    assign sdo_oe_o = sdo_oe_reg;

    // frame statistics for software
    logic [15:0] good_frames_reg;
    logic [15:0] short_frames_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            good_frames_reg  <= 16'h0000;
            short_frames_reg <= 16'h0000;
        end else if (sel_rise) begin
            if (frame_full) begin
                good_frames_reg <= good_frames_reg + 16'h0001;
            end else begin
                short_frames_reg <= short_frames_reg + 16'h0001;
            end
        end
    end

    // wishbone slave: one wait state, ack dropped after one cycle
    logic wb_req;

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    // write lands on the edge at which the master sees ack
    logic wb_wr_done;

    assign wb_wr_done = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // control write; link enable gates new frames, never cuts one short
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_en_reg <= CTRL_RESET;
        end else if (wb_wr_done && wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
            link_en_reg <= wb_dat_i[0];
        end
    end

    // read mux, registered with the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= UNMAPPED_READ;
        end else if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
                OFS_CTRL:    wb_dat_o <= {30'h0000_0000, in_frame_reg, link_en_reg};
                OFS_PRELOAD: wb_dat_o <= {16'h0000, preload_reg};
                OFS_OUTPUT:  wb_dat_o <= {16'h0000, output_reg};
                OFS_SETUP:   wb_dat_o <= {29'h0000_0000, setup_reg};
                OFS_FRAMES:  wb_dat_o <= {short_frames_reg, good_frames_reg};
                default:     wb_dat_o <= UNMAPPED_READ;
            endcase
        end
    end
endmodule

// ---- test/dac_load_props.sv ----
`timescale 1ns/1ps
module dac_load_props
    import dac_load_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        select_n_i,
    input wire logic        sclk_i,
    input wire logic        load_out_pin_n_i,
    input wire logic        clear_out_pin_n_i,
    input wire logic        powerup_level_sel_i,
    input wire logic        sdo_o,
    input wire logic        sdo_oe_o,
    input wire logic [15:0] dac_code_o,
    input wire logic        amp_power_down_o,
    input wire logic        out_pulldown_o,
    input wire logic        out_hiz_o,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [3:0] quiet_cnt;

    // idle cycles with no frame, load or clear; reset counts as activity
    always_ff @(posedge clk_i) begin
        if (rst_i || !select_n_i || !load_out_pin_n_i || !clear_out_pin_n_i) begin
            quiet_cnt <= 4'h0;
        end else if (quiet_cnt != 4'hf) begin
            quiet_cnt <= quiet_cnt + 4'h1;
        end
    end

    sdo_float_a: assert property (select_n_i [*6] |-> !sdo_oe_o)
        else $error("sdo driven while deselected");
    sdo_open_a: assert property ($rose(sdo_oe_o) |-> !select_n_i && !$past(select_n_i, 2))
        else $error("sdo enabled without select");
    sdo_edge_a: assert property (sdo_oe_o && $past(sdo_oe_o) && !select_n_i &&
        $changed(sdo_o) |-> !$past(sclk_i, 2)) else $error("sdo moved off a falling edge");
    dac_hold_a: assert property (quiet_cnt >= 4'hc |-> $stable(dac_code_o))
        else $error("output code moved with no cause");
    clear_force_a: assert property (!clear_out_pin_n_i [*6] |->
        dac_code_o == (powerup_level_sel_i ? CODE_MIDSCALE : CODE_ZERO))
        else $error("clear pin did not force power-up level");
    pd_decode_a: assert property (out_hiz_o || out_pulldown_o |->
        amp_power_down_o && !(out_hiz_o && out_pulldown_o)) else $error("bad power-down mix");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("wishbone request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    reset_quiet_a: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> !sdo_oe_o && !wb_ack_o && !amp_power_down_o) else $error("reset state wrong");

    cover property ($rose(select_n_i) ##6 select_n_i);
    cover property (!load_out_pin_n_i ##1 $changed(dac_code_o));
    cover property (wb_ack_o);
endmodule

bind dac_serial_load_control dac_load_props i_props (
    .clk_i, .rst_i, .select_n_i, .sclk_i, .load_out_pin_n_i, .clear_out_pin_n_i,
    .powerup_level_sel_i, .sdo_o, .sdo_oe_o, .dac_code_o, .amp_power_down_o,
    .out_pulldown_o, .out_hiz_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o
);

// ---- test/spi_host_model.sv ----
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic clk_i,
    input  wire logic sdo_i,
    output logic      select_n_o,
    output logic      sclk_o,
    output logic      sdi_o
);
    initial begin
        select_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end

    // n bits msb first; low 5 clocks, high 3 (160 ns per bit) so synced sdo settles
    task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = '0;
        @(posedge clk_i);
        select_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = n - 1; i >= 0; i--) begin
            sdi_o <= tx[i];
            repeat (5) @(posedge clk_i);
            rx = {rx[30:0], sdo_i};
            sclk_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        select_n_o <= 1'b1;
        sdi_o <= ~sdi_o; // released data line must not hold its last bit
        repeat (8) @(posedge clk_i);
    endtask
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
    import dac_load_pkg::*;
    typedef struct packed {
        logic [4:0]  op;
        logic [2:0]  ch;
        logic [15:0] d;
        logic [5:0]  n;
        logic [15:0] rd;
        logic [15:0] dac;
        logic [2:0]  pwr;
    } step_t;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        select_n_i, sclk_i, sdi_i, sdo_o, sdo_oe_o, wb_ack_o;
    logic        load_out_pin_n_i = 1'b1;
    logic        clear_out_pin_n_i = 1'b1;
    logic        powerup_level_sel_i = 1'b1;
    logic        amp_power_down_o, out_pulldown_o, out_hiz_o;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic [15:0] dac_code_o;
    logic [23:0] shadow = 24'h00_0000;
    logic        primed = 1'b0;
    int          fail_count = 0;
    int          checks = 0;
    int          short_frames = 0;
    wire         sdo_line = sdo_oe_o ? sdo_o : 1'bz;
    // channel zero in every row but the refused one
    step_t steps[19] = '{
        '{OP_WRITE_MODE, 3'h0, 16'h1234, 6'd24, 16'h0000, 16'h8000, 3'h0},
        '{OP_SOFT_LOAD, 3'h0, 16'h0000, 6'd24, 16'h0000, 16'h1234, 3'h0},
        '{OP_UPDATE_WRITE, 3'h0, 16'h1111, 6'd24, 16'h0000, 16'h1111, 3'h0},
        '{OP_WRITE_ALL, 3'h0, 16'h2222, 6'd24, 16'h0000, 16'h2222, 3'h0},
        '{OP_SET_MODE, 3'h0, 16'h0001, 6'd24, 16'h0000, 16'h2222, 3'h0},
        '{OP_WRITE_MODE, 3'h0, 16'h4321, 6'd24, 16'h0000, 16'h4321, 3'h0},
        '{OP_READ_SETUP, 3'h0, 16'h0000, 6'd24, 16'h0004, 16'h4321, 3'h0},
        '{OP_READ_PRELOAD, 3'h0, 16'h0000, 6'd24, 16'h4321, 16'h4321, 3'h0},
        '{OP_READ_OUTPUT, 3'h0, 16'h0000, 6'd24, 16'h4321, 16'h4321, 3'h0},
        '{OP_SET_MODE, 3'h0, 16'h0000, 6'd24, 16'h0000, 16'h4321, 3'h0},
        '{OP_WRITE_ALL, 3'h1, 16'h5555, 6'd24, 16'h0000, 16'h4321, 3'h0},
        '{5'h1f, 3'h0, 16'h5555, 6'd24, 16'h0000, 16'h4321, 3'h0},
        '{OP_WRITE_ALL, 3'h0, 16'h5555, 6'd20, 16'h0000, 16'h4321, 3'h0},
        '{OP_WRITE_ALL, 3'h0, 16'h6666, 6'd32, 16'h0000, 16'h6666, 3'h0},
        '{OP_POWER_DOWN, 3'h0, 16'h0002, 6'd24, 16'h0000, 16'h6666, 3'h6},
        '{OP_POWER_DOWN, 3'h0, 16'h0003, 6'd24, 16'h0000, 16'h6666, 3'h5},
        '{OP_POWER_DOWN, 3'h0, 16'h0000, 6'd24, 16'h0000, 16'h6666, 3'h0},
        '{OP_WRITE_MODE, 3'h0, 16'h3333, 6'd24, 16'h0000, 16'h6666, 3'h0},
        '{OP_SOFT_CLEAR, 3'h0, 16'h0000, 6'd24, 16'h0000, 16'h8000, 3'h0}
    };

    always #10 clk_i = ~clk_i;

    dac_serial_load_control i_dut (
        .clk_i, .rst_i, .select_n_i, .sclk_i, .sdi_i, .sdo_o, .sdo_oe_o,
        .load_out_pin_n_i, .clear_out_pin_n_i, .powerup_level_sel_i, .dac_code_o,
        .amp_power_down_o, .out_pulldown_o, .out_hiz_o, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o
    );
    spi_host_model i_host (
        .clk_i, .sdo_i(sdo_line), .select_n_o(select_n_i), .sclk_o(sclk_i), .sdi_o(sdi_i)
    );

    task automatic end_of_test();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // classic single cycle; a missing ack within 20 cycles ends the run
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                           output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wdat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            fail_count++;
            end_of_test();
        end
    endtask

    // shadow mirrors the shift register so every frame's echo is predicted
    task automatic send(input step_t s);
        logic [31:0] tx, rx, exp_rx;
        tx = {8'ha5, s.op, s.ch, s.d};
        exp_rx = '0;
        for (int i = int'(s.n) - 1; i >= 0; i--) begin
            exp_rx = {exp_rx[30:0], shadow[23]};
            shadow = {shadow[22:0], tx[i]};
        end
        i_host.frame(tx, int'(s.n), rx);
        if (s.n < 6'd24) short_frames++;
        if (s.n >= 6'd24 && s.op inside {OP_READ_PRELOAD, OP_READ_OUTPUT, OP_READ_SETUP}) begin
            shadow[15:0] = s.rd;
        end
        if (primed) check(rx, exp_rx);
        primed = 1'b1;
        check({16'h0000, dac_code_o}, {16'h0000, s.dac});
        check({29'h0, amp_power_down_o, out_pulldown_o, out_hiz_o}, {29'h0, s.pwr});
    endtask

    initial begin
        logic [31:0] r;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        check({16'h0000, dac_code_o}, {16'h0000, CODE_MIDSCALE});
        wb_xfer(1'b0, OFS_CTRL, 32'h0000_0000, r);
        check(r, 32'h0000_0001);
        wb_xfer(1'b0, 8'h14, 32'h0000_0000, r);
        check(r, UNMAPPED_READ);
        wb_xfer(1'b0, OFS_SETUP, 32'h0000_0000, r);
        check(r, 32'h0000_0000);
        foreach (steps[k]) send(steps[k]);
        // load pin moves only between frames
        load_out_pin_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        check({16'h0000, dac_code_o}, 32'h0000_3333);
        send('{OP_WRITE_MODE, 3'h0, 16'h7777, 6'd24, 16'h0000, 16'h7777, 3'h0});
        load_out_pin_n_i <= 1'b1;
        clear_out_pin_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        check({16'h0000, dac_code_o}, {16'h0000, CODE_MIDSCALE});
        clear_out_pin_n_i <= 1'b1;
        // strap moves only while clear is high, so the forced level is settled
        powerup_level_sel_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        clear_out_pin_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        check({16'h0000, dac_code_o}, {16'h0000, CODE_ZERO});
        clear_out_pin_n_i <= 1'b1;
        wb_xfer(1'b0, OFS_FRAMES, 32'h0000_0000, r);
        check({16'h0000, r[31:16]}, 32'(short_frames));
        // link disabled: a full write frame must leave the output alone
        wb_xfer(1'b1, OFS_CTRL, 32'h0000_0000, r);
        i_host.frame({8'ha5, OP_WRITE_ALL, CHAN_ZERO, 16'h9999}, 24, r);
        check({16'h0000, dac_code_o}, {16'h0000, CODE_ZERO});
        end_of_test();
    end
endmodule
